//--- hw/fio_core.sv
// Sequencer and datapath of the grade, rule and weighted-sum operations.
// Assumes a same-clock data memory returning read data one cycle after mem_rd.
`include "fio_defines.svh"

// Overview of operation
// - Sum products and weights over n pairs
// - Operands 8-bit unsigned, count up to 255
// - Weighted sum takes 8n+9 cycles
// - Grade one trapezoid, store at second pointer
// - Advance definition pointer four, input one
// - Rule element is offset from base
// - Element fe separates, not an offset
// - Separator inverts the overflow flag
// - Flag clear antecedent, set consequent
// - Loop until ff, stop on interrupt
// - Store minimum only if exceeding output
module fio_core (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Issue
  input wire logic start,
  input wire fio_pkg::fio_op_t op,
  input wire logic [`FIO_DATA_W-1:0] in_a,
  input wire logic [`FIO_DATA_W-1:0] in_b,
  input wire logic [`FIO_WORD_W-1:0] in_x,
  input wire logic [`FIO_WORD_W-1:0] in_y,
  input wire logic in_v,
  input wire logic irq_req,
  // Result
  output logic busy,
  output logic done,
  output logic intr_stop,
  output logic [`FIO_DATA_W-1:0] res_a,
  output logic [`FIO_DATA_W-1:0] res_b,
  output logic [`FIO_WORD_W-1:0] res_x,
  output logic [`FIO_WORD_W-1:0] res_y,
  output logic res_v,
  // Data memory
  output logic mem_rd,
  output logic mem_wr,
  output logic [`FIO_WORD_W-1:0] mem_addr,
  output logic [`FIO_DATA_W-1:0] mem_wdata,
  input wire logic [`FIO_DATA_W-1:0] mem_rdata
);
  import fio_pkg::*;

  fio_state_t state_q;
  logic [`FIO_STEP_W-1:0] step_q;
  logic [`FIO_DATA_W-1:0] a_q, b_q, cnt_q, s_q, f_q;
  logic [`FIO_WORD_W-1:0] x_q, y_q, sum_w_q;
  logic [2*`FIO_WORD_W-1:0] sum_p_q;
  logic v_q, busy_q, done_q, intr_q;
  logic mem_rd_q, mem_wr_q;
  logic [`FIO_WORD_W-1:0] mem_addr_q;
  logic [`FIO_DATA_W-1:0] mem_wdata_q;
  logic [`FIO_DATA_W-1:0] mf_q [4];
  logic [`FIO_DATA_W-1:0] grade;
  logic is_end, is_sep;

  function automatic logic [`FIO_WORD_W-1:0] adr_add(input logic [`FIO_WORD_W-1:0] base,
                                                      input logic [`FIO_WORD_W-1:0] ofs);
    adr_add = base + ofs;
  endfunction

  assign is_end = (mem_rdata == `FIO_END_BYTE);
  assign is_sep = (mem_rdata == `FIO_SEP_BYTE);

  // ----------------------------------------------------------------
  // Grade unit
  // ----------------------------------------------------------------
  fio_grade u_grade (
    .in_val(a_q),
    .pt1(mf_q[0]),
    .pt2(mf_q[1]),
    .slope1(mf_q[2]),
    .slope2(mf_q[3]),
    .grade(grade)
  );

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      state_q <= FIO_ST_IDLE;
      step_q <= `FIO_ZERO_STEP;
    end else begin
      unique case (state_q)
        FIO_ST_IDLE: begin
          step_q <= `FIO_ZERO_STEP;
          if (start) begin
            unique case (op)
              FIO_OP_GRADE: state_q <= FIO_ST_MF_RD;
              FIO_OP_RULES: state_q <= FIO_ST_RV_FETCH;
              FIO_OP_WSUM: state_q <= (in_b == `FIO_ZERO_BYTE) ? FIO_ST_WS_TAIL : FIO_ST_WS_ITER;
              default: state_q <= FIO_ST_IDLE;
            endcase
          end
        end
        FIO_ST_MF_RD: begin
          step_q <= step_q + `FIO_ONE_STEP;
          if (step_q == `FIO_MF_LAST) state_q <= FIO_ST_MF_WR;
        end
        FIO_ST_MF_WR: state_q <= FIO_ST_IDLE;
        FIO_ST_RV_FETCH: state_q <= irq_req ? FIO_ST_IDLE : FIO_ST_RV_EW;
        FIO_ST_RV_EW: state_q <= FIO_ST_RV_EL;
        FIO_ST_RV_EL: state_q <= is_end ? FIO_ST_IDLE :
                                 (is_sep ? FIO_ST_RV_FETCH : FIO_ST_RV_OW);
        FIO_ST_RV_OW: state_q <= FIO_ST_RV_OP;
        FIO_ST_RV_OP: state_q <= FIO_ST_RV_FETCH;
        FIO_ST_WS_ITER: begin
          step_q <= step_q + `FIO_ONE_STEP;
          if (step_q == `FIO_WS_ITER_LAST) begin
            step_q <= `FIO_ZERO_STEP;
            if (cnt_q == `FIO_CNT_ONE) state_q <= FIO_ST_WS_TAIL;
          end
        end
        FIO_ST_WS_TAIL: begin
          step_q <= step_q + `FIO_ONE_STEP;
          if (step_q == `FIO_WS_TAIL_LAST) state_q <= FIO_ST_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Working registers and pointers
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      a_q <= `FIO_ZERO_BYTE;
      b_q <= `FIO_ZERO_BYTE;
      x_q <= `FIO_ZERO_WORD;
      y_q <= `FIO_ZERO_WORD;
      v_q <= 1'b0;
      cnt_q <= `FIO_ZERO_BYTE;
      s_q <= `FIO_ZERO_BYTE;
      f_q <= `FIO_ZERO_BYTE;
      sum_p_q <= `FIO_ZERO_SUM;
      sum_w_q <= `FIO_ZERO_WORD;
      mf_q <= '{default: `FIO_ZERO_BYTE};
    end else begin
      unique case (state_q)
        FIO_ST_IDLE: begin
          if (start) begin
            a_q <= in_a;
            b_q <= in_b;
            x_q <= in_x;
            y_q <= in_y;
            v_q <= in_v;
            cnt_q <= in_b;
            sum_p_q <= `FIO_ZERO_SUM;
            sum_w_q <= `FIO_ZERO_WORD;
          end
        end
        FIO_ST_MF_RD: begin
          if (step_q >= `FIO_MF_CAP_FIRST) mf_q[2'(step_q - `FIO_MF_CAP_FIRST)] <= mem_rdata;
        end
        FIO_ST_MF_WR: begin
          x_q <= adr_add(x_q, `FIO_MF_STRIDE);
          y_q <= adr_add(y_q, `FIO_FI_STRIDE);
        end
        FIO_ST_RV_FETCH: if (!irq_req) x_q <= adr_add(x_q, `FIO_FI_STRIDE);
        FIO_ST_RV_EL: begin
          if (is_sep && !is_end) begin
            v_q <= ~v_q;
            if (v_q) a_q <= `FIO_END_BYTE;
          end
        end
        FIO_ST_RV_OP: if (!v_q && (mem_rdata < a_q)) a_q <= mem_rdata;
        FIO_ST_WS_ITER: begin
          if (step_q == `FIO_WS_CAP_S) s_q <= mem_rdata;
          if (step_q == `FIO_WS_CAP_F) f_q <= mem_rdata;
          if (step_q == `FIO_WS_MAC) begin
            sum_p_q <= sum_p_q + {`FIO_ZERO_WORD, 16'(s_q) * 16'(f_q)};
            sum_w_q <= sum_w_q + {`FIO_ZERO_BYTE, f_q};
          end
          if (step_q == `FIO_WS_ITER_LAST) begin
            x_q <= adr_add(x_q, `FIO_FI_STRIDE);
            y_q <= adr_add(y_q, `FIO_FI_STRIDE);
            cnt_q <= cnt_q - `FIO_CNT_ONE;
          end
        end
        FIO_ST_WS_TAIL: begin
          if (step_q == `FIO_WS_TAIL_LAST) begin
            x_q <= sum_w_q;
            y_q <= sum_p_q[2*`FIO_WORD_W-1:`FIO_WORD_W];
            a_q <= sum_p_q[`FIO_WORD_W-1:`FIO_DATA_W];
            b_q <= sum_p_q[`FIO_DATA_W-1:0];
          end
        end
        default: ;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Memory port
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      mem_rd_q <= 1'b0;
      mem_wr_q <= 1'b0;
      mem_addr_q <= `FIO_ZERO_WORD;
      mem_wdata_q <= `FIO_ZERO_BYTE;
    end else begin
      mem_rd_q <= 1'b0;
      mem_wr_q <= 1'b0;
      unique case (state_q)
        FIO_ST_MF_RD: begin
          if (step_q <= `FIO_MF_LAST_RD) begin
            mem_rd_q <= 1'b1;
            mem_addr_q <= adr_add(x_q, {{(`FIO_WORD_W-`FIO_STEP_W){1'b0}}, step_q});
          end
        end
        FIO_ST_MF_WR: begin
          mem_wr_q <= 1'b1;
          mem_addr_q <= y_q;
          mem_wdata_q <= grade;
        end
        FIO_ST_RV_FETCH: begin
          if (!irq_req) begin
            mem_rd_q <= 1'b1;
            mem_addr_q <= x_q;
          end
        end
        FIO_ST_RV_EL: begin
          if (!is_end && !is_sep) begin
            mem_rd_q <= 1'b1;
            mem_addr_q <= adr_add(y_q, {`FIO_ZERO_BYTE, mem_rdata});
          end
        end
        FIO_ST_RV_OP: begin
          if (v_q && (a_q > mem_rdata)) begin
            mem_wr_q <= 1'b1;
            mem_wdata_q <= a_q;
          end
        end
        FIO_ST_WS_ITER: begin
          if (step_q == `FIO_WS_RD_S) begin
            mem_rd_q <= 1'b1;
            mem_addr_q <= x_q;
          end
          if (step_q == `FIO_WS_RD_F) begin
            mem_rd_q <= 1'b1;
            mem_addr_q <= y_q;
          end
        end
        default: ;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Completion status
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      busy_q <= 1'b0;
      done_q <= 1'b0;
      intr_q <= 1'b0;
    end else begin
      done_q <= 1'b0;
      if ((state_q == FIO_ST_IDLE) && start) begin
        busy_q <= 1'b1;
        intr_q <= 1'b0;
      end
      if ((state_q == FIO_ST_MF_WR) ||
          ((state_q == FIO_ST_RV_EL) && is_end) ||
          ((state_q == FIO_ST_WS_TAIL) && (step_q == `FIO_WS_TAIL_LAST))) begin
        busy_q <= 1'b0;
        done_q <= 1'b1;
      end
      if ((state_q == FIO_ST_RV_FETCH) && irq_req) begin
        busy_q <= 1'b0;
        done_q <= 1'b1;
        intr_q <= 1'b1;
      end
    end
  end

  assign {busy, done, intr_stop, res_v} = {busy_q, done_q, intr_q, v_q};
  assign {res_a, res_b, res_x, res_y} = {a_q, b_q, x_q, y_q};
  assign {mem_rd, mem_wr, mem_addr, mem_wdata} = {mem_rd_q, mem_wr_q, mem_addr_q, mem_wdata_q};

endmodule

//--- hw/fio_grade.sv
// Trapezoid grade of one input value on one membership definition.
// Assumes registered operands from the sequencer; purely combinational.
`include "fio_defines.svh"

module fio_grade (
  // Operands
  input wire logic [`FIO_DATA_W-1:0] in_val,
  input wire logic [`FIO_DATA_W-1:0] pt1,
  input wire logic [`FIO_DATA_W-1:0] pt2,
  input wire logic [`FIO_DATA_W-1:0] slope1,
  input wire logic [`FIO_DATA_W-1:0] slope2,
  // Result
  output logic [`FIO_DATA_W-1:0] grade
);
  import fio_pkg::*;

  logic [`FIO_DATA_W:0] d1;
  logic [`FIO_DATA_W:0] d2;
  logic outside;
  logic [`FIO_WORD_W-1:0] g1;
  logic [`FIO_WORD_W-1:0] g2;

  // ----------------------------------------------------------------
  // Deltas, side grades and clipping
  // ----------------------------------------------------------------
  always_comb begin
    d1 = {1'b0, in_val} - {1'b0, pt1};
    d2 = {1'b0, pt2} - {1'b0, in_val};
    outside = d1[`FIO_DATA_W] | d2[`FIO_DATA_W];
    g1 = outside ? `FIO_ZERO_WORD : d1[`FIO_DATA_W-1:0] * slope1;
    g2 = outside ? `FIO_ZERO_WORD : d2[`FIO_DATA_W-1:0] * slope2;
    if (((slope2 == `FIO_ZERO_BYTE) || (g2 > `FIO_GRADE_LIM)) && !outside) begin
      grade = `FIO_GRADE_MAX;
    end else begin
      grade = g2[`FIO_DATA_W-1:0];
    end
    if (!(((slope1 == `FIO_ZERO_BYTE) || (g1 > `FIO_GRADE_LIM)) && !outside)) begin
      grade = g1[`FIO_DATA_W-1:0];
    end
  end

endmodule

//--- shared/fio_defines.svh
// Named constants of the fuzzy inference execution unit.
// Assumes inclusion by bare name from every design file that needs them.
`ifndef FIO_DEFINES_SVH
`define FIO_DEFINES_SVH

// ----------------------------------------------------------------
// Widths
// ----------------------------------------------------------------
`define FIO_DATA_W 8
`define FIO_WORD_W 16
`define FIO_STEP_W 4

// ----------------------------------------------------------------
// Reset and special values
// ----------------------------------------------------------------
`define FIO_ZERO_BYTE 8'h00
`define FIO_ZERO_WORD 16'h0000
`define FIO_ZERO_SUM 32'h0000_0000
`define FIO_ZERO_STEP 4'h0
`define FIO_ONE_STEP 4'h1
`define FIO_SEP_BYTE 8'hfe
`define FIO_END_BYTE 8'hff
`define FIO_GRADE_MAX 8'hff
`define FIO_GRADE_LIM 16'h00ff
`define FIO_CNT_ONE 8'h01

// ----------------------------------------------------------------
// Pointer strides
// ----------------------------------------------------------------
`define FIO_MF_STRIDE 16'h0004
`define FIO_FI_STRIDE 16'h0001

// ----------------------------------------------------------------
// Step counts
// ----------------------------------------------------------------
`define FIO_MF_LAST_RD 4'h3
`define FIO_MF_CAP_FIRST 4'h2
`define FIO_MF_LAST 4'h5
`define FIO_WS_RD_S 4'h0
`define FIO_WS_RD_F 4'h1
`define FIO_WS_CAP_S 4'h2
`define FIO_WS_CAP_F 4'h3
`define FIO_WS_MAC 4'h4
`define FIO_WS_ITER_LAST 4'h7
`define FIO_WS_TAIL_LAST 4'h8

`endif

//--- shared/fio_pkg.sv
// Types of the fuzzy inference execution unit.
// Assumes nothing beyond a SystemVerilog compiler.
package fio_pkg;

  // ----------------------------------------------------------------
  // Operation select
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    FIO_OP_GRADE,
    FIO_OP_RULES,
    FIO_OP_WSUM
  } fio_op_t;

  // ----------------------------------------------------------------
  // Sequencer states
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    FIO_ST_IDLE,
    FIO_ST_MF_RD,
    FIO_ST_MF_WR,
    FIO_ST_RV_FETCH,
    FIO_ST_RV_EW,
    FIO_ST_RV_EL,
    FIO_ST_RV_OW,
    FIO_ST_RV_OP,
    FIO_ST_WS_ITER,
    FIO_ST_WS_TAIL
  } fio_state_t;

endpackage

//--- tb/fio_core_sva.sv
// Checker of the fuzzy inference unit, bound to its top module.
// Assumes the design constants header and package are compiled first.
`include "fio_defines.svh"

module fio_core_sva (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Issue
  input wire logic start,
  input wire fio_pkg::fio_op_t op,
  input wire logic [`FIO_DATA_W-1:0] in_b,
  input wire logic [`FIO_WORD_W-1:0] in_x,
  input wire logic [`FIO_WORD_W-1:0] in_y,
  input wire logic irq_req,
  // Result
  input wire logic busy,
  input wire logic done,
  input wire logic intr_stop,
  input wire logic [`FIO_WORD_W-1:0] res_x,
  input wire logic [`FIO_WORD_W-1:0] res_y,
  // Data memory
  input wire logic mem_rd,
  input wire logic mem_wr,
  input wire logic [`FIO_WORD_W-1:0] mem_addr,
  input wire logic [`FIO_DATA_W-1:0] mem_wdata,
  input wire logic [`FIO_DATA_W-1:0] mem_rdata
);
  import fio_pkg::*;
  logic take;
  fio_op_t op_q;
  logic [15:0] x0_q;
  logic [15:0] y0_q;
  logic [7:0] n0_q;
  logic [11:0] cnt_q;
  assign take = start && !busy;
  // --------------------------------
  // Operands of the running op
  // --------------------------------
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      op_q <= FIO_OP_GRADE;
      x0_q <= 16'h0000;
      y0_q <= 16'h0000;
      n0_q <= 8'h00;
    end else if (take) begin
      op_q <= op;
      x0_q <= in_x;
      y0_q <= in_y;
      n0_q <= in_b;
    end
  end
  // Cycles since issue
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      cnt_q <= 12'h000;
    end else if (take) begin
      cnt_q <= 12'h001;
    end else begin
      cnt_q <= cnt_q + 12'h001;
    end
  end
  // --------------------------------
  // Properties
  // --------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  AST_GRADE_TIME: assert property (take && op == FIO_OP_GRADE
    |=> !done [*7] ##1 done) else $error("Grade op finished at wrong cycle");
  AST_GRADE_PTRS: assert property (done && op_q == FIO_OP_GRADE
    |-> res_x == x0_q + 16'h0004 && res_y == y0_q + 16'h0001)
    else $error("Grade pointers not advanced by four and one");
  AST_GRADE_WR: assert property (mem_wr && op_q == FIO_OP_GRADE
    |-> mem_addr == y0_q) else $error("Grade stored away from input pointer");
  AST_GRADE_RD: assert property (mem_rd && op_q == FIO_OP_GRADE
    |-> mem_addr - x0_q < 16'h0004) else $error("Grade read outside its definition");
  AST_WSUM_TIME: assert property (done && op_q == FIO_OP_WSUM
    |-> cnt_q == {4'h0, n0_q} * 12'h008 + 12'h00a) else $error("Weighted sum length wrong");
  AST_RV_MAX: assert property (mem_wr && op_q == FIO_OP_RULES
    |-> mem_wdata > $past(mem_rdata)) else $error("Output written without exceeding it");
  AST_RV_WADDR: assert property (mem_wr && op_q == FIO_OP_RULES
    |-> $past(mem_rd, 2) && mem_addr == $past(mem_addr, 2) && mem_addr - y0_q < 16'h0100)
    else $error("Output write address not the offset read");
  AST_IRQ_STOP: assert property (busy && op_q == FIO_OP_RULES && irq_req
    |-> ##[0:8] (done && intr_stop)) else $error("Rule loop ignored interrupt");
  cover property (done && op_q == FIO_OP_WSUM);
  cover property (done && intr_stop);
  cover property (mem_wr && op_q == FIO_OP_RULES);
endmodule

bind fio_core fio_core_sva u_sva (.clk, .rst_b, .start, .op, .in_b, .in_x, .in_y,
  .irq_req, .busy, .done, .intr_stop, .res_x, .res_y, .mem_rd, .mem_wr, .mem_addr,
  .mem_wdata, .mem_rdata);

//--- tb/fio_mem_model.sv
// Data memory holding program tables, fuzzy inputs and outputs.
// Assumes the unit's clock and a one-cycle registered read.
module fio_mem_model (
  // Clock
  input wire logic clk,
  // Access
  input wire logic mem_rd,
  input wire logic mem_wr,
  input wire logic [15:0] mem_addr,
  input wire logic [7:0] mem_wdata,
  output logic [7:0] mem_rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] ram [0:65535];
  logic [7:0] rdata_q = 8'h00;
  logic valid_q = 1'b0;
  always @(posedge clk) begin
    if (mem_wr) begin
      ram[mem_addr] <= mem_wdata;
    end
    valid_q <= mem_rd;
    if (mem_rd) begin
      rdata_q <= ram[mem_addr];
    end
  end
  // Stale read data shows inverted
  assign mem_rdata = valid_q ? rdata_q : ~rdata_q;
endmodule

//--- tb/testbench.sv
// Self-checking bench of the fuzzy inference unit.
// Assumes the unit, its checker and the memory model are compiled first.
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import fio_pkg::*;
  logic clk = 1'b0;
  logic rst_b, start, in_v, irq_req, busy, done, intr_stop, res_v, mem_rd, mem_wr;
  fio_op_t op;
  logic [7:0] in_a, in_b, res_a, res_b, mem_wdata, mem_rdata;
  logic [15:0] in_x, in_y, res_x, res_y, mem_addr;
  int num_errors = 0;
  int checked = 0;
  int cycles;
  fio_core dut (.clk, .rst_b, .start, .op, .in_a, .in_b, .in_x, .in_y, .in_v, .irq_req,
    .busy, .done, .intr_stop, .res_a, .res_b, .res_x, .res_y, .res_v, .mem_rd, .mem_wr,
    .mem_addr, .mem_wdata, .mem_rdata);
  fio_mem_model mem (.clk, .mem_rd, .mem_wr, .mem_addr, .mem_wdata, .mem_rdata);
  always #12.5 clk = ~clk;
  // --------------------------------
  // Shared tasks
  // --------------------------------
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic load(input logic [15:0] base, input logic [127:0] bytes, input int n);
    for (int i = 0; i < n; i++) begin
      mem.ram[base + 16'(i)] = bytes[8 * (n - i) - 1 -: 8];
    end
  endtask
  task automatic issue(input fio_op_t o, input logic [7:0] a, input logic [7:0] b,
      input logic [15:0] x, input logic [15:0] y, input logic v, input int irq_at);
    @(posedge clk);
    start <= 1'b1;
    irq_req <= 1'b0;
    op <= o;
    in_a <= a;
    in_b <= b;
    in_x <= x;
    in_y <= y;
    in_v <= v;
    @(posedge clk);
    start <= 1'b0;
    #1;
    check(busy, 1'b1);
    cycles = 0;
    while (cycles < 3000) begin
      @(posedge clk);
      cycles++;
      if (cycles == irq_at) irq_req <= 1'b1;
      #1;
      if (done === 1'b1) break;
    end
    check(done, 1'b1);
  endtask
  // --------------------------------
  // Scenarios
  // --------------------------------
  task automatic test_grade();
    load(16'h0100, 128'h20e0_0404_0030_0008_40ff_0404, 12);
    for (int i = 0; i < 3; i++) begin
      issue(FIO_OP_GRADE, 8'h28, 8'h00, 16'h0100 + 16'(4 * i), 16'h0200 + 16'(i), 1'b0, 0);
      check(cycles, 7);
      check(res_x, 16'h0104 + 16'(4 * i));
      check(res_y, 16'h0201 + 16'(i));
    end
    @(posedge clk);
    #1;
    check({mem.ram[16'h0200], mem.ram[16'h0201], mem.ram[16'h0202]}, 24'h204000);
  endtask
  task automatic test_rules(input int irq_at);
    load(16'h0300, 128'h8040_c010_0000_0000_0000, 10);
    load(16'h0400, 128'h0001fe08_fe0203fe_0809fe02_fe09feff, 16);
    issue(FIO_OP_RULES, 8'hff, 8'h00, 16'h0400, 16'h0300, 1'b0, irq_at);
    if (irq_at > 0) begin
      check(intr_stop, 1'b1);
      issue(FIO_OP_RULES, res_a, 8'h00, res_x, 16'h0300, res_v, 0);
    end
    check(intr_stop, 1'b0);
    check({mem.ram[16'h0308], mem.ram[16'h0309]}, 16'h40c0);
    check(res_x, 16'h0410);
    check(res_v, 1'b0);
  endtask
  task automatic test_wsum(input int n);
    logic [31:0] sp;
    logic [15:0] sw;
    logic [7:0] s;
    logic [7:0] f;
    sp = 0;
    sw = 0;
    for (int i = 0; i < n; i++) begin
      s = 8'(i * 7 + 3);
      f = 8'hff - 8'(i);
      mem.ram[16'h0500 + 16'(i)] = s;
      mem.ram[16'h0700 + 16'(i)] = f;
      sp = sp + s * f;
      sw = sw + f;
    end
    issue(FIO_OP_WSUM, 8'h00, 8'(n), 16'h0500, 16'h0700, 1'b0, 0);
    check({res_y, res_a, res_b}, sp);
    check(res_x, sw);
    check(cycles, 8 * n + 9);
    if (n > 0) check({res_y, res_a, res_b} / res_x, sp / sw);
  endtask
  task automatic complete_run();
    $display("checks %0d errors %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // --------------------------------
  // Main sequence and watchdog
  // --------------------------------
  initial begin
    rst_b = 1'b0;
    start = 1'b0;
    op = FIO_OP_GRADE;
    in_a = 8'h00;
    in_b = 8'h00;
    in_x = 16'h0000;
    in_y = 16'h0000;
    in_v = 1'b0;
    irq_req = 1'b0;
    repeat (6) @(posedge clk);
    rst_b <= 1'b1;
    #1;
    check({busy, done, mem_wr}, 3'h0);
    test_grade();
    test_rules(0);
    test_rules(20);
    test_wsum(0);
    test_wsum(3);
    test_wsum(255);
    complete_run();
  end
  initial begin
    repeat (20000) @(posedge clk);
    num_errors++;
    complete_run();
  end
endmodule
